/* File: acsr_pkg.sv */
package acsr_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int POR_TIME_MS    = 1;
    localparam int POR_CYCLES     = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SAMP_PERIOD_NS = 8100;
    localparam int SAMP_CYCLES    = SAMP_PERIOD_NS / CLK_PERIOD_NS;
    // 2.5 external clock periods, counted in clock edges
    localparam int EXT_SAMP_EDGES = 5;
    localparam int EXT_IDLE_CYCLES = 64;
    localparam int SCK_HALF_DEF   = 8;
    localparam int CONV_TICKS_DEF = 16;
    localparam int F0_HALF_DEF    = 4;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int CFG_BITS   = 8;
    localparam int RES_BITS   = FRAME_BITS - 1;
    localparam int EOC_POS    = FRAME_BITS - 1;

    // ------------------------------------------------------------
    // device sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POR    = 3'h0,
        ST_CONV   = 3'h1,
        ST_SLEEP  = 3'h3,
        ST_SCK_HI = 3'h2,
        ST_SCK_LO = 3'h6,
        ST_EXT    = 3'h4
    } acsr_state_t;

endpackage

/* File: acsr_link_if.sv */
`timescale 1ns/10ps
interface acsr_link_if;
    logic sck_dev;
    logic sck_dev_oe;
    logic sck_host;
    logic sck_host_oe;
    logic sck;
    logic sdo;
    logic sdi;
    logic cs_n;
    logic f0;

    // weak pull-up wins only when nobody drives the clock pin
    assign sck = sck_dev_oe ? sck_dev : (sck_host_oe ? sck_host : 1'b1);

    modport dev (
        output sck_dev,
        output sck_dev_oe,
        output sdo,
        input  sck,
        input  sdi,
        input  cs_n,
        input  f0
    );

    modport host (
        output sck_host,
        output sck_host_oe,
        output sdi,
        output cs_n,
        output f0,
        input  sck,
        input  sdo
    );
endinterface

/* File: acsr_fifo.sv */
`timescale 1ns/10ps
module acsr_fifo #(
    parameter int W = 32,
    parameter int D = 4
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    initial begin
        if (D < 2 || (1 << AW) != D) begin
            $error("acsr_fifo: depth must be a power of two, at least 2");
        end
    end

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;
    logic         push;
    logic         pop;

    assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
    assign in_ready_o  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                         || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

/* File: acsr_dev.sv */
`timescale 1ns/10ps
module acsr_dev
    import acsr_pkg::*;
#(
    parameter int POR_LEN    = acsr_pkg::POR_CYCLES,
    parameter int SCK_HALF   = acsr_pkg::SCK_HALF_DEF,
    parameter int CONV_TICKS = acsr_pkg::CONV_TICKS_DEF
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          nrst_i,
    acsr_link_if.dev                           link,
    input  wire logic [acsr_pkg::RES_BITS-1:0] res_i,
    output logic      [acsr_pkg::CFG_BITS-1:0] cfg_o,
    output logic                               cfg_valid_o,
    output logic                               int_sck_mode_o,
    output logic                               ext_osc_o,
    output logic                               busy_o,
    output logic                               sample_tick_o
);
    localparam int TW = $clog2(POR_LEN + 1);
    localparam int SW = $clog2(SAMP_CYCLES + 1);
    localparam int CW = $clog2(CONV_TICKS + 1);
    localparam int IW = $clog2(EXT_IDLE_CYCLES + 1);

    initial begin
        if (SCK_HALF < 4 || SCK_HALF >= POR_LEN || CONV_TICKS < 1) begin
            $error("acsr_dev: parameter values out of range");
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sck_s1_reg;
    logic sck_s2_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;
    logic f0_s1_reg;
    logic f0_s2_reg;
    logic f0_s3_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
            f0_s1_reg  <= 1'b0;
            f0_s2_reg  <= 1'b0;
            f0_s3_reg  <= 1'b0;
        end else begin
            sck_s1_reg <= link.sck;
            sck_s2_reg <= sck_s1_reg;
            sdi_s1_reg <= link.sdi;
            sdi_s2_reg <= sdi_s1_reg;
            f0_s1_reg  <= link.f0;
            f0_s2_reg  <= f0_s1_reg;
            f0_s3_reg  <= f0_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // sampling clock: internal divider or external clock
    // ------------------------------------------------------------
    logic          f0_edge;
    logic [IW-1:0] idle_reg;
    logic          ext_osc_reg;
    logic [SW-1:0] samp_cnt_reg;
    logic [2:0]    edge_cnt_reg;
    logic          tick_reg;

    assign f0_edge = f0_s2_reg ^ f0_s3_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idle_reg    <= IW'(EXT_IDLE_CYCLES);
            ext_osc_reg <= 1'b0;
        end else begin
            if (f0_edge) begin
                idle_reg <= '0;
            end else if (idle_reg != IW'(EXT_IDLE_CYCLES)) begin
                idle_reg <= idle_reg + 1'b1;
            end
            ext_osc_reg <= idle_reg != IW'(EXT_IDLE_CYCLES);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            samp_cnt_reg <= '0;
            edge_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (ext_osc_reg) begin
            samp_cnt_reg <= '0;
            tick_reg     <= 1'b0;
            if (f0_edge) begin
                if (edge_cnt_reg == 3'(EXT_SAMP_EDGES - 1)) begin
                    edge_cnt_reg <= '0;
                    tick_reg     <= 1'b1;
                end else begin
                    edge_cnt_reg <= edge_cnt_reg + 1'b1;
                end
            end
        end else begin
            edge_cnt_reg <= '0;
            if (samp_cnt_reg == SW'(SAMP_CYCLES - 1)) begin
                samp_cnt_reg <= '0;
                tick_reg     <= 1'b1;
            end else begin
                samp_cnt_reg <= samp_cnt_reg + 1'b1;
                tick_reg     <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    acsr_state_t         state_reg;
    acsr_state_t         state_next;
    logic [TW-1:0]       tmr_reg;
    logic [CW-1:0]       conv_cnt_reg;
    logic [5:0]          bit_cnt_reg;
    logic                half_end;
    logic                conv_end;

    assign half_end = tmr_reg == TW'(SCK_HALF - 1);
    assign conv_end = tick_reg && conv_cnt_reg == CW'(CONV_TICKS - 1);

    // chip select is never consulted: the mode and the cycle run on their own
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_POR: begin
                if (tmr_reg == TW'(POR_LEN - 1)) begin
                    state_next = sck_s2_reg ? ST_CONV : ST_EXT;
                end
            end
            ST_CONV: begin
                if (conv_end) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP, ST_SCK_LO: begin
                if (half_end) begin
                    state_next = ST_SCK_HI;
                end
            end
            ST_SCK_HI: begin
                if (half_end) begin
                    state_next = (bit_cnt_reg == 6'(FRAME_BITS)) ? ST_CONV : ST_SCK_LO;
                end
            end
            ST_EXT: begin
                state_next = ST_EXT;
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ST_POR;
            tmr_reg   <= '0;
        end else begin
            state_reg <= state_next;
            tmr_reg   <= (state_next != state_reg) ? '0 : tmr_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conv_cnt_reg <= '0;
        end else if (state_reg != ST_CONV || conv_end) begin
            conv_cnt_reg <= '0;
        end else if (tick_reg) begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            int_sck_mode_o <= 1'b0;
        end else if (state_reg == ST_POR && state_next != ST_POR) begin
            int_sck_mode_o <= sck_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // pins and shift registers
    // ------------------------------------------------------------
    logic                  sck_reg;
    logic                  sck_oe_reg;
    logic                  sdo_reg;
    logic [FRAME_BITS-1:0] tx_sh_reg;
    logic [FRAME_BITS-1:0] rx_sh_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_reg     <= 1'b1;
            sck_oe_reg  <= 1'b0;
            sdo_reg     <= 1'b1;
            tx_sh_reg   <= '0;
            rx_sh_reg   <= '0;
            bit_cnt_reg <= '0;
        end else if (state_next != state_reg) begin
            case (state_next)
                ST_CONV: begin
                    sck_reg    <= 1'b1;
                    sdo_reg    <= 1'b1;
                    sck_oe_reg <= 1'b1;
                end
                ST_SLEEP: begin
                    sck_reg     <= 1'b0;
                    sdo_reg     <= 1'b0;
                    tx_sh_reg   <= {1'b0, res_i};
                    bit_cnt_reg <= '0;
                end
                ST_SCK_HI: begin
                    sck_reg     <= 1'b1;
                    rx_sh_reg   <= {rx_sh_reg[FRAME_BITS-2:0], sdi_s2_reg};
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                end
                ST_SCK_LO: begin
                    sck_reg   <= 1'b0;
                    tx_sh_reg <= {tx_sh_reg[FRAME_BITS-2:0], 1'b0};
                    sdo_reg   <= tx_sh_reg[FRAME_BITS-2];
                end
                default: begin
                    sck_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_o       <= '0;
            cfg_valid_o <= 1'b0;
            busy_o      <= 1'b0;
        end else begin
            cfg_valid_o <= 1'b0;
            busy_o      <= state_next == ST_CONV;
            if (state_reg == ST_SCK_HI && state_next == ST_CONV) begin
                cfg_o       <= rx_sh_reg[FRAME_BITS-1 -: CFG_BITS];
                cfg_valid_o <= 1'b1;
            end
        end
    end

    assign link.sck_dev    = sck_reg;
    assign link.sck_dev_oe = sck_oe_reg;
    assign link.sdo        = sdo_reg;
    assign ext_osc_o       = ext_osc_reg;
    assign sample_tick_o   = tick_reg;
endmodule

/* File: acsr_host.sv */
`timescale 1ns/10ps
module acsr_host
    import acsr_pkg::*;
#(
    parameter int F0_HALF    = acsr_pkg::F0_HALF_DEF,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic                            core_clk_i,
    input  wire logic                            nrst_i,
    acsr_link_if.host                            link,
    input  wire logic                            force_ext_sck_i,
    input  wire logic                            ext_osc_en_i,
    input  wire logic [acsr_pkg::CFG_BITS-1:0]   cfg_i,
    output logic      [acsr_pkg::FRAME_BITS-1:0] word_o,
    output logic                                 word_valid_o,
    input  wire logic                            word_ready_i,
    output logic                                 overrun_o
);
    initial begin
        if (F0_HALF < 1 || F0_HALF > 255) begin
            $error("acsr_host: F0_HALF out of range");
        end
    end

    // ------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------
    logic [4:0]            cnt_reg;
    logic [FRAME_BITS-1:0] rx_sh_reg;
    logic [FRAME_BITS-1:0] rx_word_reg;
    logic                  done_tgl_reg;
    logic [CFG_BITS-1:0]   cfg_sh_reg;
    logic [CFG_BITS-1:0]   cfg_shadow_reg;
    logic                  sdi_reg;

    // bit 31 of each word is the end-of-conversion bit from the first rise
    always_ff @(posedge link.sck or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg      <= '0;
            rx_sh_reg    <= '0;
            rx_word_reg  <= '0;
            done_tgl_reg <= 1'b0;
            cfg_sh_reg   <= '0;
        end else begin
            cnt_reg   <= cnt_reg + 1'b1;
            rx_sh_reg <= {rx_sh_reg[FRAME_BITS-2:0], link.sdo};
            if (cnt_reg == 5'(FRAME_BITS - 1)) begin
                rx_word_reg  <= {rx_sh_reg[FRAME_BITS-2:0], link.sdo};
                done_tgl_reg <= ~done_tgl_reg;
                cfg_sh_reg   <= cfg_shadow_reg;
            end
        end
    end

    // next input bit is set up on each falling edge
    always_ff @(negedge link.sck or negedge nrst_i) begin
        if (!nrst_i) begin
            sdi_reg <= 1'b0;
        end else if (cnt_reg < 5'(CFG_BITS)) begin
            sdi_reg <= cfg_sh_reg[3'(CFG_BITS - 1) - cnt_reg[2:0]];
        end else begin
            sdi_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // core domain: word crossing, strap and external clock
    // ------------------------------------------------------------
    logic                  done_s1_reg;
    logic                  done_s2_reg;
    logic                  done_s3_reg;
    logic                  done_pulse;
    logic [FRAME_BITS-1:0] pend_word_reg;
    logic                  pend_valid_reg;
    logic                  fifo_in_ready;
    logic                  strap_reg;
    logic                  f0_reg;
    logic [7:0]            f0_cnt_reg;

    assign done_pulse = done_s2_reg ^ done_s3_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
        end else begin
            done_s1_reg <= done_tgl_reg;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
        end
    end

    // a new word wins over the push that drains the old one
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_word_reg  <= '0;
            pend_valid_reg <= 1'b0;
            cfg_shadow_reg <= '0;
            overrun_o      <= 1'b0;
        end else begin
            overrun_o <= done_pulse && pend_valid_reg && !fifo_in_ready;
            if (done_pulse) begin
                pend_word_reg  <= rx_word_reg;
                pend_valid_reg <= 1'b1;
                cfg_shadow_reg <= cfg_i;
            end else if (fifo_in_ready) begin
                pend_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_reg <= 1'b0;
        end else begin
            strap_reg <= force_ext_sck_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            f0_reg     <= 1'b0;
            f0_cnt_reg <= '0;
        end else if (!ext_osc_en_i) begin
            f0_reg     <= 1'b0;
            f0_cnt_reg <= '0;
        end else if (f0_cnt_reg == 8'(F0_HALF - 1)) begin
            f0_reg     <= ~f0_reg;
            f0_cnt_reg <= '0;
        end else begin
            f0_cnt_reg <= f0_cnt_reg + 1'b1;
        end
    end

    acsr_fifo #(
        .W (FRAME_BITS),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .nrst_i      (nrst_i),
        .in_data_i   (pend_word_reg),
        .in_valid_i  (pend_valid_reg),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (word_o),
        .out_valid_o (word_valid_o),
        .out_ready_i (word_ready_i)
    );

    assign link.sck_host    = 1'b0;
    assign link.sck_host_oe = strap_reg;
    assign link.sdi         = sdi_reg;
    assign link.cs_n        = 1'b0;
    assign link.f0          = f0_reg;
endmodule

/* File: acsr_assertions.sv */
`timescale 1ns/10ps
module acsr_assertions #(
    parameter int SCK_HALF = 8
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic sck_dev,
    input wire logic sck_dev_oe,
    input wire logic sck_host,
    input wire logic sck_host_oe,
    input wire logic sck,
    input wire logic sdo,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic f0
);
    // ----------------------------------------
    // high run length and rising edges per frame
    // ----------------------------------------
    logic [15:0] hi_cnt_reg;
    logic [5:0]  rise_cnt_reg;
    logic        sck_reg;
    logic        conv_end;

    assign conv_end = sck_dev_oe && sck_reg && !sck && (hi_cnt_reg > 16'(2 * SCK_HALF));

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_reg <= 1'b1;
        end else begin
            sck_reg <= sck;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt_reg <= 16'h0;
        end else begin
            hi_cnt_reg <= sck ? hi_cnt_reg + 16'h1 : 16'h0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rise_cnt_reg <= 6'h0;
        end else if (conv_end) begin
            rise_cnt_reg <= 6'h0;
        end else if (sck && !sck_reg) begin
            rise_cnt_reg <= rise_cnt_reg + 6'h1;
        end
    end

    // ----------------------------------------
    // link checks
    // ----------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_drive_kept: assert property ($past(sck_dev_oe) |-> sck_dev_oe)
        else $error("clock drive dropped");
    chk_sleep_state: assert property (conv_end |-> (!sck && !sdo)[*8] ##1 (sck && !sdo))
        else $error("sleep phase wrong");
    chk_low_phase: assert property (sck_dev_oe && $fell(sck) |-> (!sck)[*8] ##1 sck)
        else $error("low phase length wrong");
    chk_high_phase: assert property (sck_dev_oe && $rose(sck) |-> sck[*8])
        else $error("high phase too short");
    chk_frame_rises: assert property (sck_dev_oe && sck_reg && sck && $rose(sdo)
        |-> rise_cnt_reg == 6'h20)
        else $error("frame edge count wrong");
    chk_sdo_on_fall: assert property (sck_dev_oe && $past(sck_dev_oe) && $changed(sdo)
        |-> $fell(sck) || (sck && $past(sck) && sdo))
        else $error("data changed off falling edge");
    chk_conv_levels: assert property (sck_dev_oe && sck && hi_cnt_reg > 16'(2 * SCK_HALF)
        |-> sdo)
        else $error("data low during conversion");
    chk_conv_bound: assert property (sck_dev_oe && sck |-> hi_cnt_reg < 16'h1000)
        else $error("conversion never ends");
    chk_cs_tied: assert property (cs_n == 1'b0)
        else $error("select not held low");
endmodule

/* File: adc_continuous_internal_sck_readout_test.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module adc_continuous_internal_sck_readout_test;
    import acsr_pkg::*;
    localparam int POR_L = 200;
    localparam int F0_H  = 4;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic force_ext_sck_i = 1'b0;
    logic ext_osc_en_i = 1'b0;
    logic word_ready_i = 1'b0;
    logic [RES_BITS-1:0] res_i = '0;
    logic [RES_BITS-1:0] rnd_res;
    logic [CFG_BITS-1:0] cfg_i = '0;
    logic [CFG_BITS-1:0] rnd_cfg;
    logic [CFG_BITS-1:0] cfg_o;
    logic [CFG_BITS-1:0] exp_c;
    logic [FRAME_BITS-1:0] word_o;
    logic [FRAME_BITS-1:0] exp_w;
    logic cfg_valid_o, int_sck_mode_o, ext_osc_o, busy_o, sample_tick_o;
    logic word_valid_o, overrun_o, busy_q;
    logic [FRAME_BITS-1:0] wq[$];
    logic [CFG_BITS-1:0] cq[$];
    int num_errors = 0;
    int tests_run = 0;
    int seed = 86;
    int gap = 0;
    int exp_gap = SAMP_CYCLES;
    int overruns = 0;
    bit tick_on = 1'b0;
    bit tick_seen = 1'b0;

    acsr_link_if link ();
    acsr_dev #(.POR_LEN(POR_L), .SCK_HALF(8), .CONV_TICKS(2)) u_acsr_dev (.core_clk_i,
        .nrst_i, .link(link), .res_i, .cfg_o, .cfg_valid_o, .int_sck_mode_o, .ext_osc_o,
        .busy_o, .sample_tick_o);
    acsr_host #(.F0_HALF(F0_H)) u_acsr_host (.core_clk_i, .nrst_i,
        .link(link), .force_ext_sck_i, .ext_osc_en_i, .cfg_i, .word_o, .word_valid_o,
        .word_ready_i, .overrun_o);
    acsr_assertions u_acsr_assertions (.core_clk_i, .nrst_i,
        .sck_dev(link.sck_dev), .sck_dev_oe(link.sck_dev_oe), .sck_host(link.sck_host),
        .sck_host_oe(link.sck_host_oe), .sck(link.sck), .sdo(link.sdo), .sdi(link.sdi),
        .cs_n(link.cs_n), .f0(link.f0));

    // ----------------------------------------
    // clock, watchdog, verdict
    // ----------------------------------------
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (80000) @(posedge core_clk_i);
        num_errors++;
        give_verdict();
    end

    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // new sample and config per conversion, noted on the queues
    // ----------------------------------------
    always @(posedge core_clk_i) begin
        busy_q <= busy_o;
        if (busy_o === 1'b1 && busy_q === 1'b0) begin
            rnd_res = RES_BITS'($random(seed));
            rnd_cfg = CFG_BITS'($random(seed));
            res_i <= rnd_res;
            cfg_i <= rnd_cfg;
            wq.push_back({1'b0, rnd_res});
            cq.push_back(rnd_cfg);
        end
    end

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge core_clk_i) begin
        if (word_valid_o === 1'b1 && word_ready_i === 1'b1) begin
            exp_w = wq.pop_front();
            `CHK("word", exp_w, word_o)
        end
        if (overrun_o === 1'b1) begin
            wq.delete(4);
            overruns++;
        end
        if (cfg_valid_o === 1'b1) begin
            exp_c = cq.pop_front();
            `CHK("config", exp_c, cfg_o)
        end
        gap++;
        if (!tick_on) begin
            tick_seen = 1'b0;
        end
        if (sample_tick_o === 1'b1) begin
            if (tick_on && tick_seen) begin
                `CHK("tick gap", exp_gap, gap)
            end
            tick_seen = 1'b1;
            gap = 0;
        end
    end

    // mode: 0 ready low, 1 ready high, 2 random ready
    task automatic run_frames(input int n, input int mode);
        repeat (n) begin
            @(posedge core_clk_i);
            while (cfg_valid_o !== 1'b1) begin
                word_ready_i <= (mode == 2) ? 1'($random(seed)) : (mode == 1);
                @(posedge core_clk_i);
            end
        end
    endtask

    initial begin
        // config sampled at a frame's end reaches the link two frames later
        cq.push_back('0);
        cq.push_back('0);
        repeat (12) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (POR_L + 4) @(posedge core_clk_i);
        `CHK("strap", 1'b1, int_sck_mode_o)
        `CHK("clock drive", 1'b1, link.sck_dev_oe)
        tick_on <= 1'b1;
        run_frames(3, 2);
        run_frames(1, 1);
        run_frames(6, 0);
        `CHK("overruns", 1, overruns)
        run_frames(1, 1);
        tick_on <= 1'b0;
        ext_osc_en_i <= 1'b1;
        repeat (200) @(posedge core_clk_i);
        `CHK("ext osc", 1'b1, ext_osc_o)
        exp_gap <= EXT_SAMP_EDGES * F0_H;
        tick_on <= 1'b1;
        run_frames(2, 1);
        tick_on <= 1'b0;
        ext_osc_en_i <= 1'b0;
        force_ext_sck_i <= 1'b1;
        repeat (100) @(posedge core_clk_i);
        `CHK("osc idle", 1'b0, ext_osc_o)
        nrst_i <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        wq.delete();
        cq.delete();
        nrst_i <= 1'b1;
        repeat (POR_L + 4) @(posedge core_clk_i);
        `CHK("strap low", 1'b0, int_sck_mode_o)
        repeat (3000) @(posedge core_clk_i);
        `CHK("no drive", 1'b0, link.sck_dev_oe)
        `CHK("no convert", 1'b0, busy_o)
        give_verdict();
    end
endmodule
